// file: src/fci_host.sv
// Purpose: apb-controlled host that drives a byte-wide flash command decoder
// Assumes: pins synchronous to mclk; a bench resolves the data lines
// Notes:   one command sequence at a time; ctrl writes ignored while busy
//
// Contract
// - every operation is chosen only by writing a command byte to the device; the read-cycle op writes none and power-down drives the reset pin low
// - suspend pauses erase or write; D0H resumes; reads allowed while paused
// - block erase is 20H then D0H, both inside the block
// - byte write is 40H or 10H, then address with data byte
// - erasing or writing a locked block needs the elevated reset level
// - block lock is 60H then 01H; normal level only if master clear
// - master lock is 60H then F1H and always needs elevated level
// - 60H then D0H clears all block locks; elevated if master set
// - output enable and write strobe are never low together
// - no altering operation while reset pin sits between levels
// - undefined command codes are not written
// - a read drives select and output enable low, write strobe high
// - 50H clears the sticky status error bits
//
// Implementation choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`include "fci_consts.svh"

module fci_host #(
	parameter int unsigned SETUP_CYC  = `FCI_SETUP_CYC,
	parameter int unsigned STROBE_CYC = `FCI_STROBE_CYC,
	parameter int unsigned HOLD_CYC   = `FCI_HOLD_CYC,
	parameter int unsigned READ_CYC   = `FCI_READ_CYC,
	parameter int unsigned PWRDN_CYC  = `FCI_PWRDN_CYC,
	parameter int unsigned WAKE_CYC   = `FCI_WAKE_CYC,
	parameter int unsigned SETTLE_CYC = `FCI_SETTLE_CYC
) (
	input  wire logic              mclk,
	input  wire logic              nrst,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	output fci_pkg::fci_pins_t     pins,
	input  wire logic [7:0]        data_lines_in,
	input  wire logic              ready_busy_n
);

	////////////////////////////////////////////////////////////////////////
	// elaboration checks: counters are eight bits wide

	if (SETUP_CYC < 1 || SETUP_CYC > 255 || STROBE_CYC < 1 || STROBE_CYC > 255 ||
	    HOLD_CYC < 1 || HOLD_CYC > 255 || READ_CYC < 1 || READ_CYC > 255 ||
	    PWRDN_CYC < 1 || PWRDN_CYC > 255 || WAKE_CYC < 1 || WAKE_CYC > 255 ||
	    SETTLE_CYC < 1 || SETTLE_CYC > 255) begin : g_bad_timing
		$error("fci_host: timing count outside 1..255");
	end

	////////////////////////////////////////////////////////////////////////
	// state

	localparam fci_pkg::fci_state_t RST_S = '{
		st:       fci_pkg::ST_IDLE,
		cnt:      8'h00,
		op:       fci_pkg::OP_READ_ARRAY,
		elev:     1'b0,
		vpp:      1'b0,
		wait_rdy: 1'b0,
		alt:      1'b0,
		addr:     20'h00000,
		wdata:    8'h00,
		rdata:    8'h00,
		busy:     1'b0,
		done:     1'b0,
		err:      1'b0,
		need_w2:  1'b0,
		need_rd:  1'b0,
		byte2:    8'h00,
		pins:     '{
			addr:               20'h00000,
			data_out:           8'h00,
			data_lines_oe:      1'b0,
			ce_n:               1'b1,
			oe_n:               1'b1,
			we_n:               1'b1,
			reset_powerdown_n:  1'b1,
			elevated_unlock_en: 1'b0,
			program_supply_en:  1'b0
		}
	};

	fci_pkg::fci_state_t q;
	fci_pkg::fci_state_t d;
	logic                acc;
	logic                hit;

	assign acc    = psel & penable;
	assign hit    = (paddr == `FCI_OFS_CTRL) || (paddr == `FCI_OFS_ADDR) ||
	                (paddr == `FCI_OFS_WDATA) || (paddr == `FCI_OFS_RDATA) ||
	                (paddr == `FCI_OFS_STATUS);
	// zero wait states keeps software polling cheap
	assign pready  = 1'b1;
	assign pslverr = acc & ~hit;
	assign pins    = q.pins;

	////////////////////////////////////////////////////////////////////////
	// register read mux

	always_comb begin
		prdata = 32'h0000_0000;
		case (paddr)
			`FCI_OFS_CTRL: begin
				prdata[`FCI_CTRL_OP_LSB +: 4] = q.op;
				prdata[`FCI_CTRL_ELEV]        = q.elev;
				prdata[`FCI_CTRL_VPP]         = q.vpp;
				prdata[`FCI_CTRL_WAIT]        = q.wait_rdy;
				prdata[`FCI_CTRL_ALT]         = q.alt;
			end
			`FCI_OFS_ADDR:  prdata[19:0] = q.addr;
			`FCI_OFS_WDATA: prdata[7:0]  = q.wdata;
			`FCI_OFS_RDATA: prdata[7:0]  = q.rdata;
			`FCI_OFS_STATUS: begin
				prdata[`FCI_STAT_BUSY] = q.busy;
				prdata[`FCI_STAT_DONE] = q.done;
				prdata[`FCI_STAT_ERR]  = q.err;
				prdata[`FCI_STAT_RDY]  = ready_busy_n;
			end
			default: prdata = 32'h0000_0000;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		logic       start;
		logic       fin;
		logic       last;
		logic       w1;
		logic       w2;
		logic       rd;
		logic       pd;
		logic       bad;
		logic [7:0] b1;
		logic [7:0] b2;
		start = 1'b0;
		fin   = 1'b0;
		last  = 1'b0;
		w1    = 1'b1;
		w2    = 1'b0;
		rd    = 1'b0;
		pd    = 1'b0;
		bad   = 1'b0;
		b1    = 8'h00;
		b2    = 8'h00;
		d     = q;

		// supply and level controls only change while idle
		if (acc && pwrite && !q.busy) begin
			case (paddr)
				`FCI_OFS_CTRL: begin
					d.op       = fci_pkg::fci_op_t'(pwdata[`FCI_CTRL_OP_LSB +: 4]);
					d.elev     = pwdata[`FCI_CTRL_ELEV];
					d.vpp      = pwdata[`FCI_CTRL_VPP];
					d.wait_rdy = pwdata[`FCI_CTRL_WAIT];
					d.alt      = pwdata[`FCI_CTRL_ALT];
					start      = pwdata[`FCI_CTRL_START];
					d.pins.elevated_unlock_en = pwdata[`FCI_CTRL_ELEV];
					d.pins.program_supply_en  = pwdata[`FCI_CTRL_VPP];
				end
				`FCI_OFS_ADDR:  d.addr  = pwdata[19:0];
				`FCI_OFS_WDATA: d.wdata = pwdata[7:0];
				default: d.busy = q.busy;
			endcase
		end
		if (acc && pwrite && paddr == `FCI_OFS_STATUS) begin
			d.done = q.done & ~pwdata[`FCI_STAT_DONE];
			d.err  = q.err & ~pwdata[`FCI_STAT_ERR];
		end

		case (q.st)
			fci_pkg::ST_IDLE: begin
				if (start) begin
					case (d.op)
						fci_pkg::OP_READ_ARRAY:  b1 = `FCI_CMD_READ_ARRAY;
						fci_pkg::OP_READ_IDENT: begin
							b1 = `FCI_CMD_READ_IDENT;
							rd = 1'b1;
						end
						fci_pkg::OP_READ_STATUS: begin
							b1 = `FCI_CMD_READ_STAT;
							rd = 1'b1;
						end
						fci_pkg::OP_CLEAR_STAT:  b1 = `FCI_CMD_CLEAR_STAT;
						fci_pkg::OP_ERASE: begin
							b1 = `FCI_CMD_ERASE;
							b2 = `FCI_CMD_CONFIRM;
							w2 = 1'b1;
						end
						fci_pkg::OP_BYTE_WRITE: begin
							b1 = d.alt ? `FCI_CMD_WRITE_ALT : `FCI_CMD_WRITE;
							b2 = d.wdata;
							w2 = 1'b1;
						end
						fci_pkg::OP_SUSPEND:     b1 = `FCI_CMD_SUSPEND;
						fci_pkg::OP_RESUME:      b1 = `FCI_CMD_CONFIRM;
						fci_pkg::OP_LOCK_BLOCK: begin
							b1 = `FCI_CMD_LOCK;
							b2 = `FCI_CMD_LOCK_BLOCK;
							w2 = 1'b1;
						end
						fci_pkg::OP_LOCK_MASTER: begin
							b1 = `FCI_CMD_LOCK;
							b2 = `FCI_CMD_LOCK_MASTER;
							w2 = 1'b1;
						end
						fci_pkg::OP_CLEAR_LOCKS: begin
							b1 = `FCI_CMD_LOCK;
							b2 = `FCI_CMD_CONFIRM;
							w2 = 1'b1;
						end
						fci_pkg::OP_READ_CYCLE: begin
							w1 = 1'b0;
							rd = 1'b1;
						end
						fci_pkg::OP_POWER_DOWN: begin
							w1 = 1'b0;
							pd = 1'b1;
						end
						default: bad = 1'b1;
					endcase
					if (bad) begin
						d.err = 1'b1; // reserved codes never reach the pins
					end else begin
						d.busy      = 1'b1;
						d.need_w2   = w2;
						d.need_rd   = rd;
						d.byte2     = b2;
						d.pins.addr = d.addr;
						// master lock always needs the elevated level
						if (d.op == fci_pkg::OP_LOCK_MASTER) begin
							d.pins.elevated_unlock_en = 1'b1;
						end
						if (pd) begin
							d.st                     = fci_pkg::ST_PWRDN;
							d.pins.reset_powerdown_n = 1'b0;
							d.cnt                    = 8'(PWRDN_CYC - 1);
						end else if (w1) begin
							d.st                 = fci_pkg::ST_SETUP;
							d.pins.data_out      = b1;
							d.pins.data_lines_oe = 1'b1;
							d.pins.ce_n          = 1'b0;
							d.cnt                = 8'(SETUP_CYC - 1);
						end else begin
							d.st        = fci_pkg::ST_READ;
							d.pins.ce_n = 1'b0;
							d.pins.oe_n = 1'b0;
							d.cnt       = 8'(READ_CYC - 1);
						end
					end
				end
			end
			fci_pkg::ST_SETUP: begin
				if (q.cnt == 8'h00) begin
					d.st        = fci_pkg::ST_STROBE;
					d.pins.we_n = 1'b0; // oe_n is high in every write state
					d.cnt       = 8'(STROBE_CYC - 1);
				end else begin
					d.cnt = q.cnt - 8'h01;
				end
			end
			fci_pkg::ST_STROBE: begin
				if (q.cnt == 8'h00) begin
					// strobe rises first while select and data still stand
					d.st        = fci_pkg::ST_RELEASE;
					d.pins.we_n = 1'b1;
					d.cnt       = 8'(HOLD_CYC - 1);
				end else begin
					d.cnt = q.cnt - 8'h01;
				end
			end
			fci_pkg::ST_RELEASE: begin
				if (q.cnt == 8'h00) begin
					d.st                 = fci_pkg::ST_GAP;
					d.pins.ce_n          = 1'b1;
					d.pins.data_lines_oe = 1'b0;
					d.cnt                = 8'(HOLD_CYC - 1);
				end else begin
					d.cnt = q.cnt - 8'h01;
				end
			end
			fci_pkg::ST_READ: begin
				if (q.cnt == 8'h00) begin
					// sampled before release: outputs float once oe_n rises
					d.rdata     = data_lines_in;
					d.st        = fci_pkg::ST_GAP;
					d.pins.ce_n = 1'b1;
					d.pins.oe_n = 1'b1;
					d.cnt       = 8'(HOLD_CYC - 1);
				end else begin
					d.cnt = q.cnt - 8'h01;
				end
			end
			fci_pkg::ST_GAP: begin
				if (q.cnt != 8'h00) begin
					d.cnt = q.cnt - 8'h01;
				end else if (q.need_w2) begin
					d.need_w2            = 1'b0;
					d.st                 = fci_pkg::ST_SETUP;
					d.pins.data_out      = q.byte2;
					d.pins.data_lines_oe = 1'b1;
					d.pins.ce_n          = 1'b0;
					d.cnt                = 8'(SETUP_CYC - 1);
				end else if (q.need_rd) begin
					d.need_rd   = 1'b0;
					d.st        = fci_pkg::ST_READ;
					d.pins.ce_n = 1'b0;
					d.pins.oe_n = 1'b0;
					d.cnt       = 8'(READ_CYC - 1);
				end else begin
					fin = 1'b1;
				end
			end
			fci_pkg::ST_PWRDN: begin
				if (q.cnt == 8'h00) begin
					// device comes back in array read mode
					d.st                     = fci_pkg::ST_WAKE;
					d.pins.reset_powerdown_n = 1'b1;
					d.cnt                    = 8'(WAKE_CYC - 1);
				end else begin
					d.cnt = q.cnt - 8'h01;
				end
			end
			fci_pkg::ST_WAKE: begin
				if (q.cnt == 8'h00) begin
					fin = 1'b1;
				end else begin
					d.cnt = q.cnt - 8'h01;
				end
			end
			fci_pkg::ST_WAITRDY: begin
				// settle first: the pin may not have fallen yet
				if (q.cnt != 8'h00) begin
					d.cnt = q.cnt - 8'h01;
				end else if (ready_busy_n) begin
					last = 1'b1;
				end
			end
			default: d.st = fci_pkg::ST_IDLE;
		endcase

		if (fin) begin
			if (q.wait_rdy) begin
				d.st  = fci_pkg::ST_WAITRDY;
				d.cnt = 8'(SETTLE_CYC - 1);
			end else begin
				last = 1'b1;
			end
		end
		// completion set wins over a software clear in the same cycle
		if (last) begin
			d.st                      = fci_pkg::ST_IDLE;
			d.busy                    = 1'b0;
			d.done                    = 1'b1;
			d.pins.elevated_unlock_en = q.elev;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// registers

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			q <= RST_S;
		end else begin
			q <= d;
		end
	end

endmodule

// file: src/fci_consts.svh
// Purpose: constants of the flash command host controller
// Assumes: 100 MHz mclk
// Notes:   offsets are byte addresses on the apb register bus
`ifndef FCI_CONSTS_SVH
`define FCI_CONSTS_SVH

`define FCI_CLK_MHZ         100
`define FCI_CYC(ns)         ((((ns) * `FCI_CLK_MHZ) + 999) / 1000)

`define FCI_T_SETUP_NS      20
`define FCI_T_STROBE_NS     50
`define FCI_T_HOLD_NS       20
`define FCI_T_READ_NS       100
`define FCI_T_PWRDN_NS      100
`define FCI_T_WAKE_NS       1000
`define FCI_T_SETTLE_NS     200
`define FCI_SETUP_CYC       `FCI_CYC(`FCI_T_SETUP_NS)
`define FCI_STROBE_CYC      `FCI_CYC(`FCI_T_STROBE_NS)
`define FCI_HOLD_CYC        `FCI_CYC(`FCI_T_HOLD_NS)
`define FCI_READ_CYC        `FCI_CYC(`FCI_T_READ_NS)
`define FCI_PWRDN_CYC       `FCI_CYC(`FCI_T_PWRDN_NS)
`define FCI_WAKE_CYC        `FCI_CYC(`FCI_T_WAKE_NS)
`define FCI_SETTLE_CYC      `FCI_CYC(`FCI_T_SETTLE_NS)

`define FCI_OFS_CTRL        8'h00
`define FCI_OFS_ADDR        8'h04
`define FCI_OFS_WDATA       8'h08
`define FCI_OFS_RDATA       8'h0C
`define FCI_OFS_STATUS      8'h10

`define FCI_CTRL_OP_LSB     0
`define FCI_CTRL_ELEV       4
`define FCI_CTRL_VPP        5
`define FCI_CTRL_WAIT       6
`define FCI_CTRL_ALT        7
`define FCI_CTRL_START      8
`define FCI_STAT_BUSY       0
`define FCI_STAT_DONE       1
`define FCI_STAT_ERR        2
`define FCI_STAT_RDY        3

`define FCI_CMD_READ_ARRAY  8'hFF
`define FCI_CMD_READ_IDENT  8'h90
`define FCI_CMD_READ_STAT   8'h70
`define FCI_CMD_CLEAR_STAT  8'h50
`define FCI_CMD_ERASE       8'h20
`define FCI_CMD_CONFIRM     8'hD0
`define FCI_CMD_WRITE       8'h40
`define FCI_CMD_WRITE_ALT   8'h10
`define FCI_CMD_SUSPEND     8'hB0
`define FCI_CMD_LOCK        8'h60
`define FCI_CMD_LOCK_BLOCK  8'h01
`define FCI_CMD_LOCK_MASTER 8'hF1

`endif

// file: src/fci_pkg.sv
// Purpose: types of the flash command host controller
// Assumes: 20-bit flash byte address
// Notes:   constants live in fci_consts.svh
package fci_pkg;

	typedef enum logic [3:0] {
		OP_READ_ARRAY  = 4'h0,
		OP_READ_IDENT  = 4'h1,
		OP_READ_STATUS = 4'h2,
		OP_CLEAR_STAT  = 4'h3,
		OP_ERASE       = 4'h4,
		OP_BYTE_WRITE  = 4'h5,
		OP_SUSPEND     = 4'h6,
		OP_RESUME      = 4'h7,
		OP_LOCK_BLOCK  = 4'h8,
		OP_LOCK_MASTER = 4'h9,
		OP_CLEAR_LOCKS = 4'hA,
		OP_READ_CYCLE  = 4'hB,
		OP_POWER_DOWN  = 4'hC
	} fci_op_t;

	typedef enum logic [3:0] {
		ST_IDLE    = 4'h0,
		ST_SETUP   = 4'h1,
		ST_STROBE  = 4'h2,
		ST_RELEASE = 4'h3,
		ST_GAP     = 4'h4,
		ST_READ    = 4'h5,
		ST_PWRDN   = 4'h6,
		ST_WAKE    = 4'h7,
		ST_WAITRDY = 4'h8
	} fci_fsm_t;

	typedef struct packed {
		logic [19:0] addr;
		logic [7:0]  data_out;
		logic        data_lines_oe;
		logic        ce_n;
		logic        oe_n;
		logic        we_n;
		logic        reset_powerdown_n;
		logic        elevated_unlock_en;
		logic        program_supply_en;
	} fci_pins_t;

	typedef struct packed {
		fci_fsm_t    st;
		logic [7:0]  cnt;
		fci_op_t     op;
		logic        elev;
		logic        vpp;
		logic        wait_rdy;
		logic        alt;
		logic [19:0] addr;
		logic [7:0]  wdata;
		logic [7:0]  rdata;
		logic        busy;
		logic        done;
		logic        err;
		logic        need_w2;
		logic        need_rd;
		logic [7:0]  byte2;
		fci_pins_t   pins;
	} fci_state_t;

endpackage

// file: verification/fci_flash_model.sv
// Purpose: behavioural byte-wide flash that stands behind fci_host
// Assumes: 256 bytes of block 0 are kept; erase refills all of them
// Notes:   changes land at once; only the busy time is modelled
`timescale 1ns/1ps
module fci_flash_model #(
	parameter logic [7:0] MFR_CODE = 8'h3C, // arbitrary value
	parameter logic [7:0] DEV_CODE = 8'h5E, // arbitrary value
	parameter int         BUSY_NS  = 2000
) (
	input  wire fci_pkg::fci_pins_t pins,
	output logic [7:0]              data_lines,
	output logic                    ready_busy_n
);
	logic [7:0]  mem [256];
	logic [7:0]  sr;
	logic [7:0]  pend;
	logic [7:0]  rd;
	logic [7:0]  last;
	logic [1:0]  mode;
	logic [15:0] lock;
	logic        master;
	logic        susp;
	logic        drv;
	int          left;
	//////////
	task automatic wake();
		mode = 2'h0;
		sr   = 8'h80;
		pend = 8'h00;
		left = 0;
		susp = 1'b0;
	endtask
	initial begin
		foreach (mem[i]) mem[i] = 8'hFF;
		lock   = 16'h0000;
		master = 1'b0;
		last   = 8'h00;
		wake();
	end
	always @(negedge pins.reset_powerdown_n) wake();
	always #10 if (left > 0 && !susp) left = left - 10;
	assign ready_busy_n = left == 0 || susp || !pins.reset_powerdown_n;
	//////////
	task automatic first(input logic [7:0] b);
		if (left > 0 && !susp && b != 8'h70 && b != 8'hB0) return;
		case (b)
			8'hFF: mode = 2'h0;
			8'h90: mode = 2'h1;
			8'h70: mode = 2'h2;
			8'h50: sr[5:1] = 5'h00;
			8'h20, 8'h40, 8'h10, 8'h60: pend = b;
			8'hB0: susp = left > 0;
			8'hD0: susp = 1'b0;
			default: ;
		endcase
		if (b == 8'hB0 || b == 8'hD0) mode = 2'h2;
	endtask
	task automatic second(input logic [7:0] b, input logic [19:0] a);
		logic [7:0] e;
		logic       bad;
		logic       lk;
		e   = (pend == 8'h20 || (pend == 8'h60 && b == 8'hD0)) ? 8'h20 : 8'h10;
		bad = (pend == 8'h20) ? b != 8'hD0 : pend == 8'h60 && !(b inside {8'h01, 8'hF1, 8'hD0});
		lk  = (pend == 8'h60) ? (master || b == 8'hF1) : lock[a[19:16]];
		mode = 2'h2;
		if (bad) sr = sr | 8'h30;
		else if (!pins.program_supply_en) sr = sr | e | 8'h08;
		else if (lk && !pins.elevated_unlock_en) sr = sr | e | 8'h02;
		else begin
			left = BUSY_NS;
			if (pend == 8'h20) foreach (mem[i]) mem[i] = 8'hFF;
			else if (pend != 8'h60) mem[a[7:0]] = mem[a[7:0]] & b;
			else if (b == 8'hD0) lock = 16'h0000;
			else if (b == 8'hF1) master = 1'b1;
			else lock[a[19:16]] = 1'b1;
		end
		pend = 8'h00;
	endtask
	// both edges watched: whichever strobe rises first latches
	always @(posedge pins.we_n or posedge pins.ce_n) begin
		if ((pins.we_n ^ pins.ce_n) && pins.reset_powerdown_n) begin
			if (pend != 8'h00) second(data_lines, pins.addr);
			else first(data_lines);
		end
	end
	//////////
	assign drv = !pins.ce_n && !pins.oe_n && pins.reset_powerdown_n;
	always_comb begin
		case (mode)
			2'h0: rd = mem[pins.addr[7:0]];
			2'h1: rd = (pins.addr[1:0] == 2'h0) ? MFR_CODE : (pins.addr[1:0] == 2'h1) ? DEV_CODE
				: {7'h00, pins.addr[0] ? master : lock[pins.addr[19:16]]};
			default: rd = {ready_busy_n, susp, sr[5:0]};
		endcase
	end
	// a floating bus shows the inverse of its last level, never a kind guess
	always_comb begin
		if (pins.data_lines_oe) data_lines = pins.data_out;
		else if (drv) data_lines = rd;
		else data_lines = ~last;
	end
	always @(data_lines) if (pins.data_lines_oe || drv) last = data_lines;
endmodule

// file: verification/fci_host_monitor.sv
// Purpose: pin-level checks of fci_host
// Assumes: counts equal those of the bound instance
// Notes:   sees top ports only
`timescale 1ns/1ps
module fci_host_monitor #(
	parameter int unsigned STROBE_CYC = 5,
	parameter int unsigned PWRDN_CYC  = 10
) (
	input wire logic               mclk,
	input wire logic               nrst,
	input wire fci_pkg::fci_pins_t pins
);
	logic [7:0]  low_q;
	logic [7:0]  pd_q;
	logic [7:0]  cmd_q;
	logic [19:0] adr_q;
	logic        pend_q;
	default clocking dc @(posedge mclk);
	endclocking
	default disable iff (!nrst);
	//////////
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			low_q <= 8'h00;
			pd_q  <= 8'h00;
			cmd_q <= 8'h00;
			adr_q <= 20'h00000;
			pend_q <= 1'b0;
		end else begin
			low_q <= pins.we_n ? 8'h00 : low_q + 8'h01;
			// a second-cycle byte is data, so it never opens a new pair
			if (pins.we_n && low_q != 8'h00) begin
				pend_q <= !pend_q && (cmd_q inside {8'h20, 8'h40, 8'h10, 8'h60});
			end
			pd_q  <= pins.reset_powerdown_n ? 8'h00 : pd_q + 8'h01;
			if (!pins.we_n) begin
				cmd_q <= pins.data_out;
				adr_q <= pins.addr;
			end
		end
	end
	//////////
	no_overlap_a: assert property (pins.oe_n || pins.we_n)
		else $error("output enable and write strobe low together");
	read_pins_a: assert property (
		!pins.oe_n |-> !pins.ce_n && pins.we_n && !pins.data_lines_oe)
		else $error("read cycle pins wrong");
	strobe_drive_a: assert property (!pins.we_n |-> !pins.ce_n && pins.data_lines_oe)
		else $error("write strobe without select or data");
	latch_stable_a: assert property (
		!pins.we_n ##1 !pins.we_n |-> $stable(pins.data_out) && $stable(pins.addr))
		else $error("data or address moved under the strobe");
	strobe_len_a: assert property ($rose(pins.we_n) |-> low_q == STROBE_CYC && !pins.ce_n)
		else $error("strobe width wrong or select rose first");
	pwrdn_len_a: assert property ($rose(pins.reset_powerdown_n) |-> pd_q == PWRDN_CYC)
		else $error("power-down pulse width wrong");
	master_elev_a: assert property (
		$fell(pins.we_n) && pend_q && cmd_q == 8'h60 && pins.data_out == 8'hF1
		|-> pins.elevated_unlock_en)
		else $error("master lock without elevated level");
	erase_pair_a: assert property (
		$fell(pins.we_n) && pend_q && cmd_q == 8'h20
		|-> pins.data_out == 8'hD0 && pins.addr == adr_q)
		else $error("erase confirm wrong");
	cover property ($rose(pins.we_n));
	cover property ($rose(pins.oe_n));
	cover property ($rose(pins.reset_powerdown_n));
endmodule

bind fci_host fci_host_monitor #(
	.STROBE_CYC(STROBE_CYC),
	.PWRDN_CYC (PWRDN_CYC)
) fci_host_monitor_inst (
	.mclk(mclk),
	.nrst(nrst),
	.pins(pins)
);

// file: verification/fci_host_tb.sv
// Purpose: self-checking bench of fci_host against a flash model
// Assumes: wake and settle counts shortened to 2
// Notes:   each scenario is a task of its own
`timescale 1ns/1ps
module fci_host_tb;
	localparam logic [7:0] MFR = 8'h3C;
	localparam logic [7:0] DEV = 8'h5E;
	logic               mclk    = 1'b0;
	logic               nrst    = 1'b0;
	logic               psel    = 1'b0;
	logic               penable = 1'b0;
	logic               pwrite  = 1'b0;
	logic [7:0]         paddr   = 8'h00;
	logic [31:0]        pwdata  = 32'h0;
	logic [31:0]        prdata;
	logic               pready;
	logic               pslverr;
	fci_pkg::fci_pins_t pins;
	logic [7:0]         data_lines;
	logic               ready_busy_n;
	logic [31:0]        rq;
	logic [31:0]        st;
	logic               re;
	int                 n_fail    = 0;
	int                 tests_run = 0;
	always #5 mclk = ~mclk;
	fci_host #(.WAKE_CYC(2), .SETTLE_CYC(2)) fci_host_inst (
		.mclk(mclk),
		.nrst(nrst),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.pins(pins),
		.data_lines_in(data_lines),
		.ready_busy_n(ready_busy_n)
	);
	fci_flash_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) fci_flash_model_inst (
		.pins(pins),
		.data_lines(data_lines),
		.ready_busy_n(ready_busy_n)
	);
	//////////
	task automatic summarize();
		if (n_fail == 0 && tests_run > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic cut();
		n_fail++;
		summarize();
	endtask
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// answer taken at the completing edge, before that edge's updates land
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rq = prdata;
		re = pslverr;
		if (pready !== 1'b1) cut();
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk);
	endtask
	// fl is {alt, wait for ready, program supply, elevated}
	task automatic run(input logic [3:0] op, input logic [19:0] a, input logic [7:0] wd,
		input logic [3:0] fl);
		int n;
		apb(1'b1, 8'h04, {12'h000, a});
		apb(1'b1, 8'h08, {24'h0, wd});
		apb(1'b1, 8'h00, {23'h0, 1'b1, fl, op});
		n = 0;
		do begin
			apb(1'b0, 8'h10, 32'h0);
			n++;
		end while (rq[2:1] === 2'h0 && n < 500);
		if (rq[2:1] === 2'h0) cut();
		st = rq;
		apb(1'b1, 8'h10, 32'h00000006);
		apb(1'b0, 8'h0C, 32'h0);
	endtask
	task automatic rc(input logic [3:0] op, input logic [19:0] a, input logic [7:0] exp);
		run(op, a, 8'h00, 4'h0);
		chk("rdata", rq, {24'h0, exp});
	endtask
	//////////
	// ops without a read leave the last read byte in rdata
	task automatic t_modes();
		apb(1'b0, 8'h14, 32'h0);
		chk("slverr", {31'h0, re}, 32'h1);
		rc(4'hB, 20'h00005, 8'hFF);
		run(4'h5, 20'h00005, 8'h5A, 4'h6);
		rc(4'h0, 20'h00000, 8'hFF);
		rc(4'hB, 20'h00005, 8'h5A);
		rc(4'hB, 20'h00005, 8'h5A);
		run(4'h5, 20'h00006, 8'h0F, 4'hE);
		rc(4'h0, 20'h00000, 8'h5A);
		rc(4'hB, 20'h00006, 8'h0F);
		rc(4'h1, 20'h00000, MFR);
		rc(4'h1, 20'h00001, DEV);
	endtask
	task automatic t_status();
		rc(4'h2, 20'h00000, 8'h80);
		run(4'h5, 20'h00005, 8'h00, 4'h4);
		rc(4'h2, 20'h00000, 8'h98);
		rc(4'h0, 20'h00000, 8'h98);
		rc(4'hB, 20'h00005, 8'h5A);
		rc(4'h3, 20'h00000, 8'h5A);
		rc(4'h2, 20'h00000, 8'h80);
	endtask
	task automatic t_lock();
		run(4'h8, 20'h00005, 8'h00, 4'h6);
		rc(4'h1, 20'h00002, 8'h01);
		run(4'h5, 20'h00005, 8'h00, 4'h6);
		rc(4'h2, 20'h00000, 8'h92);
		rc(4'h3, 20'h00000, 8'h92);
		run(4'h5, 20'h00005, 8'h00, 4'h7);
		rc(4'h0, 20'h00000, 8'h92);
		rc(4'hB, 20'h00005, 8'h00);
		run(4'h9, 20'h00000, 8'h00, 4'h6);
		rc(4'h1, 20'h00003, 8'h01);
		run(4'hA, 20'h00000, 8'h00, 4'h6);
		rc(4'h2, 20'h00000, 8'hA2);
		rc(4'h3, 20'h00000, 8'hA2);
		run(4'hA, 20'h00000, 8'h00, 4'h7);
		rc(4'h1, 20'h00002, 8'h00);
	endtask
	task automatic t_busy();
		run(4'h4, 20'h00005, 8'h00, 4'h2);
		chk("erase st", st, 32'h00000002);
		rc(4'h0, 20'h00000, 8'h00);
		rc(4'hB, 20'h00005, 8'h00);
		run(4'h6, 20'h00000, 8'h00, 4'h0);
		chk("suspend st", st, 32'h0000000A);
		rc(4'h0, 20'h00000, 8'h00);
		rc(4'hB, 20'h00005, 8'hFF);
		run(4'h7, 20'h00000, 8'h00, 4'h0);
		chk("resume st", st, 32'h00000002);
		run(4'h0, 20'h00000, 8'h00, 4'h4);
		rc(4'hB, 20'h00005, 8'h80);
		rc(4'h0, 20'h00000, 8'h80);
		rc(4'hB, 20'h00005, 8'hFF);
	endtask
	task automatic t_wake();
		run(4'h5, 20'h00005, 8'h00, 4'h4);
		rc(4'h1, 20'h00000, MFR);
		rc(4'hC, 20'h00000, MFR);
		rc(4'hB, 20'h00005, 8'hFF);
		rc(4'h2, 20'h00000, 8'h80);
		run(4'hD, 20'h00000, 8'h00, 4'h0);
		chk("illegal st", st, 32'h0000000C);
	endtask
	initial begin
		repeat (5) @(posedge mclk);
		nrst <= 1'b1;
		@(posedge mclk);
		t_modes();
		t_status();
		t_lock();
		t_busy();
		t_wake();
		summarize();
	end
endmodule
